//--- logic/rgc_pkg.sv
// Shared constants and carrier types of the receiver gain control loop.
// Assumes a single 125 MHz system clock and a synchronous active-high reset.
package rgc_pkg;

    // ==========================================================
    // Clock and sample tick timing
    // ==========================================================
    localparam longint CLK_HZ = 125_000_000;
    // Sample tick rate in hundredths of a hertz (610.35 Hz)
    localparam longint TICK_RATE_CHZ = 61035;
    // Clock cycles per sample tick, rounded down
    localparam int TICK_CYCLES = int'((CLK_HZ * 100) / TICK_RATE_CHZ);
    localparam int TDIV_W = 18;

    // ==========================================================
    // Attenuator and integrator layout
    // ==========================================================
    localparam int WORD_W = 5;
    localparam int FRAC_W = 7;
    localparam int INT_W = WORD_W + FRAC_W;
    localparam logic [INT_W-1:0] INT_ALL_ONES = 12'hFFF;
    localparam logic [INT_W-1:0] INT_ZERO = 12'h000;
    localparam logic [WORD_W-1:0] WORD_MAX_ATTEN = 5'h1F;
    localparam int ATTEN_STEP_DB = 1;
    localparam int ATTEN_SPAN_DB = 31;
    localparam int WORD_STEP_DB = 2 * ATTEN_STEP_DB;
    localparam int RANGE_DB = 2 * ATTEN_SPAN_DB;
    // Slew in tenths of dB per second, and the ceiling on a full sweep
    localparam int SLEW_DB_X10 = 95;
    localparam int FULL_SWEEP_MS = 7000;

    // ==========================================================
    // Amplitude converter and configuration widths
    // ==========================================================
    localparam int AMP_W = 8;
    localparam int STEP_W = 4;
    localparam logic [STEP_W-1:0] STEP_MIN = 4'h1;
    localparam int SYNC_W = AMP_W + 1;

    // ==========================================================
    // Sub-phase durations, counted in sample ticks
    // ==========================================================
    localparam int TCNT_W = 16;
    localparam logic [TCNT_W-1:0] GAIN_TICKS_DEF = 16'h1200;
    localparam logic [TCNT_W-1:0] FREQ_TICKS_DEF = 16'h2000;
    localparam logic [TCNT_W-1:0] SYNC_TICKS_DEF = 16'h4000;
    localparam logic [TCNT_W-1:0] TCNT_ZERO = 16'h0000;
    localparam logic [TCNT_W-1:0] TCNT_ONE = 16'h0001;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [4:0] {
        PH_IDLE = 5'h01,
        PH_GAIN = 5'h02,
        PH_FREQ = 5'h04,
        PH_SYNC = 5'h08,
        PH_DONE = 5'h10
    } rgc_phase_t;

    typedef enum logic [1:0] {
        CV_IDLE = 2'h1,
        CV_WAIT = 2'h2
    } rgc_conv_t;

    typedef struct packed {
        logic [AMP_W-1:0] threshold;
        logic [STEP_W-1:0] up_step;
    } rgc_cfg_t;

    typedef struct packed {
        rgc_phase_t phase;
        logic loop_closed;
        logic conv_missed;
        logic tuning_done;
    } rgc_stat_t;

endpackage

//--- logic/rgc_tick_gen.sv
// Sample tick generator: one-cycle pulse every TICK_CYCLES clocks.
// Assumes clk is the system clock and reset is synchronous, active high.
`timescale 1ns/1ps

module rgc_tick_gen #(
    parameter int TICK_CYCLES = rgc_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    output logic tick
);
    import rgc_pkg::*;

    localparam logic [TDIV_W-1:0] DIV_LAST = TDIV_W'(TICK_CYCLES - 1);

    logic [TDIV_W-1:0] div_r;
    logic [TDIV_W-1:0] div_nxt;
    logic tick_r;
    logic tick_nxt;

    // ==========================================================
    // Divider next state
    // ==========================================================
    always_comb begin
        div_nxt = div_r + TDIV_W'(1);
        tick_nxt = 1'b0;
        if (div_r == DIV_LAST) begin
            div_nxt = '0;
            tick_nxt = 1'b1;
        end
    end

    // Divider registers
    always_ff @(posedge clk) begin
        if (reset) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule

//--- logic/rgc_top.sv
// Receiver gain control loop: integrator, converter handshake and tuning sub-phases.
// Assumes the amplitude converter answers conv_start with conv_ready high and
// conv_data stable, both asynchronous to clk; cfg comes from logic on clk.
`timescale 1ns/1ps

module rgc_top #(
    parameter int TICK_CYCLES = rgc_pkg::TICK_CYCLES,
    parameter logic [rgc_pkg::TCNT_W-1:0] GAIN_TICKS = rgc_pkg::GAIN_TICKS_DEF,
    parameter logic [rgc_pkg::TCNT_W-1:0] FREQ_TICKS = rgc_pkg::FREQ_TICKS_DEF,
    parameter logic [rgc_pkg::TCNT_W-1:0] SYNC_TICKS = rgc_pkg::SYNC_TICKS_DEF
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tune_start,
    input wire logic use_stored,
    input wire rgc_pkg::rgc_cfg_t cfg,
    input wire logic conv_ready,
    input wire logic [rgc_pkg::AMP_W-1:0] conv_data,
    output logic conv_start,
    output logic [rgc_pkg::WORD_W-1:0] gain_control_word,
    output logic [rgc_pkg::WORD_W-1:0] stored_word,
    output logic sample_tick,
    output rgc_pkg::rgc_stat_t stat
);
    import rgc_pkg::*;

    // ==========================================================
    // Declarations
    // ==========================================================
    logic tick;
    logic sample_tick_r;

    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic [SYNC_W-1:0] sync3_r;
    logic [SYNC_W-1:0] stable_r;
    logic [SYNC_W-1:0] stable_nxt;

    rgc_conv_t conv_st_r;
    rgc_conv_t conv_st_nxt;
    logic conv_start_r;
    logic conv_start_nxt;
    logic ready_seen_r;
    logic ready_seen_nxt;
    logic missed_r;
    logic missed_nxt;
    logic [AMP_W-1:0] amp_r;
    logic [AMP_W-1:0] amp_nxt;
    logic update_r;
    logic update_nxt;

    rgc_phase_t phase_r;
    rgc_phase_t phase_nxt;
    logic [TCNT_W-1:0] tcnt_r;
    logic [TCNT_W-1:0] tcnt_nxt;
    logic done_r;
    logic done_nxt;
    logic closed_r;
    logic closed_nxt;

    logic [INT_W-1:0] integ_r;
    logic [INT_W-1:0] integ_nxt;
    logic [WORD_W-1:0] word_r;
    logic [WORD_W-1:0] word_nxt;
    logic [WORD_W-1:0] store_r;
    logic [WORD_W-1:0] store_nxt;

    logic ready_level;
    logic [AMP_W-1:0] data_level;

    // ==========================================================
    // Functions
    // ==========================================================
    // Integrator step with saturation at both ends
    function automatic logic [INT_W-1:0] integ_step(
        input logic [INT_W-1:0] acc,
        input logic up,
        input logic [STEP_W-1:0] step
    );
        logic [INT_W:0] sum;
        logic [STEP_W-1:0] eff;
        sum = '0;
        eff = (step < STEP_MIN) ? STEP_MIN : step;
        if (up) begin
            sum = {1'b0, acc} + {{(INT_W + 1 - STEP_W){1'b0}}, eff};
            integ_step = sum[INT_W] ? INT_ALL_ONES : sum[INT_W-1:0];
        end else begin
            integ_step = (acc == INT_ZERO) ? INT_ZERO : acc - INT_W'(1);
        end
    endfunction

    // Length of a sub-phase in ticks
    function automatic logic [TCNT_W-1:0] phase_len(input rgc_phase_t ph);
        phase_len = TCNT_ZERO;
        if (ph == PH_GAIN) begin
            phase_len = GAIN_TICKS;
        end else if (ph == PH_FREQ) begin
            phase_len = FREQ_TICKS;
        end else if (ph == PH_SYNC) begin
            phase_len = SYNC_TICKS;
        end
    endfunction

    // ==========================================================
    // Sample tick
    // ==========================================================
    rgc_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .reset(reset),
        .tick(tick)
    );

    // ==========================================================
    // Converter input synchroniser
    // ==========================================================
    // A change is taken only once stages two and three agree
    always_comb begin
        stable_nxt = stable_r;
        if (sync2_r == sync3_r) begin
            stable_nxt = sync3_r;
        end
    end

    // Three-stage capture of the converter pins
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            stable_r <= '0;
        end else begin
            sync1_r <= {conv_ready, conv_data};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            stable_r <= stable_nxt;
        end
    end

    assign ready_level = stable_r[SYNC_W-1];
    assign data_level = stable_r[AMP_W-1:0];

    // ==========================================================
    // Conversion handshake
    // ==========================================================
    // One request per tick while the loop is closed; one update per result
    always_comb begin
        conv_st_nxt = conv_st_r;
        conv_start_nxt = 1'b0;
        ready_seen_nxt = ready_level;
        missed_nxt = missed_r;
        amp_nxt = amp_r;
        update_nxt = 1'b0;
        if (tune_start) begin
            conv_st_nxt = CV_IDLE;
            missed_nxt = 1'b0;
        end else if (!closed_r) begin
            conv_st_nxt = CV_IDLE;
        end else begin
            unique case (conv_st_r)
                CV_IDLE: begin
                    if (tick) begin
                        conv_start_nxt = 1'b1;
                        conv_st_nxt = CV_WAIT;
                    end
                end
                CV_WAIT: begin
                    if (ready_level && !ready_seen_r) begin
                        amp_nxt = data_level;
                        update_nxt = 1'b1;
                        conv_st_nxt = CV_IDLE;
                    end else if (tick) begin
                        // No answer within a tick: flag it and ask again
                        missed_nxt = 1'b1;
                        conv_start_nxt = 1'b1;
                    end
                end
            endcase
        end
    end

    // Handshake registers
    always_ff @(posedge clk) begin
        if (reset) begin
            conv_st_r <= CV_IDLE;
            conv_start_r <= 1'b0;
            ready_seen_r <= 1'b0;
            missed_r <= 1'b0;
            amp_r <= '0;
            update_r <= 1'b0;
        end else begin
            conv_st_r <= conv_st_nxt;
            conv_start_r <= conv_start_nxt;
            ready_seen_r <= ready_seen_nxt;
            missed_r <= missed_nxt;
            amp_r <= amp_nxt;
            update_r <= update_nxt;
        end
    end

    // ==========================================================
    // Tuning sub-phase sequencer
    // ==========================================================
    // Each sub-phase lasts a fixed count of ticks, then hands to the next
    always_comb begin
        phase_nxt = phase_r;
        tcnt_nxt = tcnt_r;
        done_nxt = done_r;
        if (tune_start) begin
            phase_nxt = PH_GAIN;
            tcnt_nxt = GAIN_TICKS;
            done_nxt = 1'b0;
        end else if (tick) begin
            unique case (phase_r)
                PH_IDLE: begin
                    phase_nxt = PH_IDLE;
                end
                PH_GAIN: begin
                    tcnt_nxt = tcnt_r - TCNT_ONE;
                    if (tcnt_r <= TCNT_ONE) begin
                        phase_nxt = PH_FREQ;
                        tcnt_nxt = phase_len(PH_FREQ);
                    end
                end
                PH_FREQ: begin
                    tcnt_nxt = tcnt_r - TCNT_ONE;
                    if (tcnt_r <= TCNT_ONE) begin
                        phase_nxt = PH_SYNC;
                        tcnt_nxt = phase_len(PH_SYNC);
                    end
                end
                PH_SYNC: begin
                    tcnt_nxt = tcnt_r - TCNT_ONE;
                    if (tcnt_r <= TCNT_ONE) begin
                        phase_nxt = PH_DONE;
                        tcnt_nxt = TCNT_ZERO;
                        done_nxt = 1'b1;
                    end
                end
                PH_DONE: begin
                    phase_nxt = PH_DONE;
                end
            endcase
        end
        closed_nxt = (phase_nxt == PH_GAIN);
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (reset) begin
            phase_r <= PH_IDLE;
            tcnt_r <= TCNT_ZERO;
            done_r <= 1'b0;
            closed_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            tcnt_r <= tcnt_nxt;
            done_r <= done_nxt;
            closed_r <= closed_nxt;
        end
    end

    // ==========================================================
    // Gain integrator and control word
    // ==========================================================
    // Seven fraction bits with unit steps move the word every 128 ticks,
    // about 2 dB per 0.21 s, so 31 word steps fit in about 6.5 s
    always_comb begin
        integ_nxt = integ_r;
        store_nxt = store_r;
        if (tune_start) begin
            if (use_stored) begin
                integ_nxt = {store_r, INT_ALL_ONES[FRAC_W-1:0]};
            end else begin
                integ_nxt = INT_ALL_ONES;
            end
        end else if (update_r && closed_r) begin
            integ_nxt = integ_step(integ_r, !(amp_r < cfg.threshold), cfg.up_step);
        end
        // Keep the final gain word as the loop opens
        if (!tune_start && phase_r == PH_GAIN && phase_nxt == PH_FREQ) begin
            store_nxt = integ_nxt[INT_W-1:FRAC_W];
        end
        // Word follows the integrator while the loop is closed and on tune_start
        if (closed_r || tune_start) begin
            word_nxt = integ_nxt[INT_W-1:FRAC_W];
        end else begin
            word_nxt = word_r;
        end
    end

    // Integrator registers; reset is the initialisation load
    always_ff @(posedge clk) begin
        if (reset) begin
            integ_r <= INT_ALL_ONES;
            word_r <= WORD_MAX_ATTEN;
            store_r <= WORD_MAX_ATTEN;
        end else begin
            integ_r <= integ_nxt;
            word_r <= word_nxt;
            store_r <= store_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Registered copy of the tick for downstream timing
    always_ff @(posedge clk) begin
        if (reset) begin
            sample_tick_r <= 1'b0;
        end else begin
            sample_tick_r <= tick;
        end
    end

    assign conv_start = conv_start_r;
    assign gain_control_word = word_r;
    assign stored_word = store_r;
    assign sample_tick = sample_tick_r;
    assign stat.phase = phase_r;
    assign stat.loop_closed = closed_r;
    assign stat.conv_missed = missed_r;
    assign stat.tuning_done = done_r;

endmodule

//--- bench/rgc_monitor.sv
// Checker for the gain control loop, bound onto the top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module rgc_monitor
    import rgc_pkg::*;
#(
    parameter int TICK_CYCLES = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tune_start,
    input wire logic use_stored,
    input wire logic conv_start,
    input wire logic [rgc_pkg::WORD_W-1:0] gain_control_word,
    input wire logic [rgc_pkg::WORD_W-1:0] stored_word,
    input wire logic sample_tick,
    input wire rgc_pkg::rgc_stat_t stat
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ====================
    // Tick spacing counter
    logic [31:0] gap_r;
    logic [31:0] gap_nxt;
    logic seen_r;
    logic seen_nxt;

    // Cycles since the last sample tick
    always_comb begin
        gap_nxt = sample_tick ? 32'h0 : gap_r + 32'h1;
        seen_nxt = seen_r | sample_tick;
        if (reset) begin
            gap_nxt = 32'h0;
            seen_nxt = 1'b0;
        end
    end

    // Register the counter
    always_ff @(posedge clk) begin
        gap_r <= gap_nxt;
        seen_r <= seen_nxt;
    end

    // ====================
    // Assertions
    AST_TICK_PERIOD: assert property (
        seen_r |-> int'(gap_r) < TICK_CYCLES && (!sample_tick || int'(gap_r) == TICK_CYCLES - 1))
        else $error("sample tick spacing wrong");
    AST_RESET_STATE: assert property (
        $fell(reset) |-> gain_control_word == WORD_MAX_ATTEN && stored_word == WORD_MAX_ATTEN
        && stat.phase == PH_IDLE) else $error("state after reset wrong");
    AST_START_GAIN: assert property (
        tune_start |=> stat.phase == PH_GAIN && !stat.tuning_done && !stat.conv_missed)
        else $error("tuning did not start in gain phase");
    AST_SEED_MAX: assert property (
        tune_start && !use_stored |=> gain_control_word == WORD_MAX_ATTEN)
        else $error("start word not maximum attenuation");
    AST_SEED_STORED: assert property (
        tune_start && use_stored |=> gain_control_word == $past(stored_word))
        else $error("start word not the stored word");
    AST_STORE_EXIT: assert property (
        stat.phase == PH_GAIN ##1 stat.phase == PH_FREQ |-> stored_word == gain_control_word)
        else $error("word not stored at gain exit");
    AST_FROZEN: assert property (
        stat.phase != PH_GAIN && !tune_start |=> $stable(gain_control_word))
        else $error("word moved with loop open");
    AST_WORD_STEP: assert property (
        stat.phase == PH_GAIN && !tune_start |=> gain_control_word == $past(gain_control_word)
        || gain_control_word == $past(gain_control_word) + 5'h1
        || gain_control_word == $past(gain_control_word) - 5'h1)
        else $error("word jumped more than one step");
    AST_CONV_ON_TICK: assert property (
        conv_start |-> sample_tick ##1 !conv_start) else $error("conversion request off tick");
    AST_DONE_FLAG: assert property (
        stat.tuning_done == (stat.phase == PH_DONE)) else $error("done flag wrong");
    AST_LOOP_FLAG: assert property (
        stat.loop_closed == (stat.phase == PH_GAIN)) else $error("loop closed flag wrong");

    // Main scenarios reached
    CV_STORED: cover property (tune_start && use_stored);
    CV_EXIT: cover property (stat.phase == PH_GAIN ##1 stat.phase == PH_FREQ);
    CV_MISSED: cover property ($rose(stat.conv_missed));
endmodule

bind rgc_top rgc_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.clk(clk), .reset(reset),
    .tune_start(tune_start), .use_stored(use_stored), .conv_start(conv_start),
    .gain_control_word(gain_control_word), .stored_word(stored_word),
    .sample_tick(sample_tick), .stat(stat));

//--- bench/rgc_conv_model.sv
// Amplitude converter model answering each conversion request.
// Assumes requests come on the design clock, at most one per tick.
`timescale 1ns/1ps

module rgc_conv_model (
    input wire logic clk,
    input wire logic conv_start,
    input wire logic answer_en,
    input wire logic [3:0] latency,
    input wire logic [rgc_pkg::AMP_W-1:0] amp,
    output logic conv_ready,
    output logic [rgc_pkg::AMP_W-1:0] conv_data
);
    import rgc_pkg::*;

    // Answer after a delay, hold 8 cycles, then show released data
    initial begin
        conv_ready = 1'b0;
        conv_data = 8'hA5;
        forever begin
            @(posedge clk);
            if (conv_start === 1'b1 && answer_en === 1'b1) begin
                repeat (latency) @(negedge clk);
                conv_data = amp;
                conv_ready = 1'b1;
                repeat (8) @(negedge clk);
                conv_ready = 1'b0;
                conv_data = ~amp;
            end
        end
    end
endmodule

//--- bench/receiver_gain_control_loop_bench.sv
// Self-checking bench for the gain control loop with a converter model.
// Assumes short tick and sub-phase parameters to keep the run brief.
`timescale 1ns/1ps

module receiver_gain_control_loop_bench;
    import rgc_pkg::*;

    localparam int TCK = 16;
    localparam logic [TCNT_W-1:0] G_TICKS = 16'h00C8;
    localparam logic [TCNT_W-1:0] F_TICKS = 16'h0008;
    localparam logic [TCNT_W-1:0] S_TICKS = 16'h0008;

    logic clk, reset, tune_start, use_stored, conv_ready, conv_start, sample_tick;
    logic answer_en, ref_on;
    logic [3:0] latency;
    logic [AMP_W-1:0] conv_data, amp;
    logic [WORD_W-1:0] gain_control_word, stored_word;
    logic [INT_W-1:0] ref_integ;
    rgc_cfg_t cfg;
    rgc_stat_t stat;
    int n_errors = 0;
    int n_compared = 0;

    rgc_top #(.TICK_CYCLES(TCK), .GAIN_TICKS(G_TICKS), .FREQ_TICKS(F_TICKS),
        .SYNC_TICKS(S_TICKS)) dut (.clk(clk), .reset(reset), .tune_start(tune_start),
        .use_stored(use_stored), .cfg(cfg), .conv_ready(conv_ready), .conv_data(conv_data),
        .conv_start(conv_start), .gain_control_word(gain_control_word),
        .stored_word(stored_word), .sample_tick(sample_tick), .stat(stat));

    rgc_conv_model u_conv (.clk(clk), .conv_start(conv_start), .answer_en(answer_en),
        .latency(latency), .amp(amp), .conv_ready(conv_ready), .conv_data(conv_data));

    // Clock of 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ====================
    // Report and compare
    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmp_word(input string what, input logic [4:0] exp, input logic [4:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_flag(input string what, input logic exp, input logic got);
        cmp_word(what, {4'h0, exp}, {4'h0, got});
    endtask

    task automatic cmp_count(input string what, input int exp, input int got);
        n_compared++;
        if (got != exp) begin
            n_errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // One bounded wait step
    task automatic step_wait(inout int n, input int bound, input string what);
        @(negedge clk);
        n++;
        if (n > bound) begin
            n_errors++;
            $display("BAD %s expected event seen timeout", what);
            end_of_test();
        end
    endtask

    task automatic wait_phase(input rgc_phase_t p, output int n);
        n = 0;
        while (stat.phase !== p) step_wait(n, 4096 + TCK * 256, "phase");
    endtask

    // ====================
    // Reference integrator
    function automatic logic [INT_W-1:0] next_integ(input logic [INT_W-1:0] v);
        logic [INT_W:0] sum;
        sum = {1'b0, v} + {9'h000, (cfg.up_step == 4'h0) ? 4'h1 : cfg.up_step};
        if (amp < cfg.threshold) return (v == 12'h000) ? v : v - 12'h001;
        return sum[INT_W] ? 12'hFFF : sum[INT_W-1:0];
    endfunction

    // Each request in gain phase: earlier updates have landed
    always @(negedge clk) begin
        if (ref_on && conv_start === 1'b1 && stat.phase === PH_GAIN) begin
            cmp_word("gain word", ref_integ[11:7], gain_control_word);
            ref_integ = next_integ(ref_integ);
        end
    end

    // ====================
    // Scenarios
    task automatic start_tune(input logic seed);
        use_stored = seed;
        tune_start = 1'b1;
        ref_integ = seed ? {stored_word, 7'h7F} : 12'hFFF;
        @(negedge clk);
        tune_start = 1'b0;
    endtask

    task automatic t_reset(input int cycles);
        reset = 1'b1;
        repeat (cycles) @(negedge clk);
        reset = 1'b0;
        cmp_word("reset word", 5'h1F, gain_control_word);
        cmp_word("reset stored", 5'h1F, stored_word);
        cmp_word("reset phase", PH_IDLE, stat.phase);
        cmp_flag("reset done", 1'b0, stat.tuning_done);
    endtask

    // Low amplitude for 200 ticks then check freezing and sub-phase lengths
    task automatic t_descend;
        int n;
        ref_on = 1'b1;
        start_tune(1'b0);
        cmp_flag("loop closed", 1'b1, stat.loop_closed);
        wait_phase(PH_FREQ, n);
        cmp_word("stored word", 5'h1E, stored_word);
        cmp_flag("loop open", 1'b0, stat.loop_closed);
        wait_phase(PH_SYNC, n);
        cmp_count("freq length", int'(F_TICKS) * TCK, n);
        wait_phase(PH_DONE, n);
        cmp_count("sync length", int'(S_TICKS) * TCK, n);
        cmp_word("frozen word", 5'h1E, gain_control_word);
        cmp_flag("done flag", 1'b1, stat.tuning_done);
    endtask

    // High amplitude, step 15, slow answers, seeded from stored word
    task automatic t_ascend;
        int n;
        amp = 8'hF0;
        cfg.up_step = 4'hF;
        latency = 4'h6;
        start_tune(1'b1);
        wait_phase(PH_FREQ, n);
        cmp_word("ceiling word", WORD_MAX_ATTEN, stored_word);
    endtask

    // No converter answer, then a restart and a reset in mid-run
    task automatic t_missed;
        int n;
        ref_on = 1'b0;
        answer_en = 1'b0;
        start_tune(1'b0);
        n = 0;
        while (stat.conv_missed !== 1'b1) step_wait(n, 3 * TCK, "missed flag");
        cmp_word("word no answer", 5'h1F, gain_control_word);
        start_tune(1'b0);
        cmp_flag("missed cleared", 1'b0, stat.conv_missed);
        cmp_word("restart phase", PH_GAIN, stat.phase);
        answer_en = 1'b1;
        repeat (40) @(negedge clk);
        t_reset(2);
    endtask

    // Main sequence
    initial begin
        reset = 1'b1;
        tune_start = 1'b0;
        use_stored = 1'b0;
        cfg = '{threshold: 8'h80, up_step: 4'h1};
        amp = 8'h10;
        answer_en = 1'b1;
        latency = 4'h1;
        ref_on = 1'b0;
        ref_integ = 12'hFFF;
        t_reset(20);
        t_descend();
        t_ascend();
        t_missed();
        end_of_test();
    end
endmodule
